// [mpjs_defines.svh]
`ifndef MPJS_DEFINES_SVH
`define MPJS_DEFINES_SVH
`define MPJS_SET_W 6
`define MPJS_POS_W 32
`define MPJS_SPD_W 16
`define MPJS_NSET 64
`define MPJS_NTRIG 4
`define MPJS_NSYNC 8
`define MPJS_SB_HOME 7
`define MPJS_SB_START 6
`define MPJS_SB_STOP 3
`define MPJS_SB_COMBO 2
`define MPJS_SET_ZERO 6'h00
`define MPJS_POS_ZERO 32'h0000_0000
`define MPJS_SPD_ZERO 16'h0000
`endif

// [mpjs_pkg.sv]
`include "mpjs_defines.svh"
package mpjs_pkg;
	typedef logic [`MPJS_SET_W-1:0] mpjs_set_t;
	typedef logic [`MPJS_POS_W-1:0] mpjs_pos_t;
	typedef logic [`MPJS_SPD_W-1:0] mpjs_spd_t;
	typedef enum logic [1:0] {
		MPJS_IDLE = 2'b00,
		MPJS_MOVE = 2'b01,
		MPJS_JOG = 2'b10
	} mpjs_state_e;
	typedef struct packed {
		logic is_final;
		logic ignore_stop;
		logic branching;
		mpjs_set_t next_a;
		mpjs_set_t next_b;
		mpjs_pos_t remain_msg;
	} mpjs_setcfg_s;
	typedef struct packed {
		mpjs_spd_t pos_speed;
		mpjs_spd_t pos_accel;
		mpjs_spd_t neg_speed;
		mpjs_spd_t neg_accel;
	} mpjs_jogcfg_s;
	typedef struct packed {
		logic setpoint_at_target;
		logic actual_at_target;
		logic remain_reached;
		logic homing_valid;
		logic trigger_hit;
	} mpjs_msg_s;
endpackage

// [mpjs_sequencer.sv]
`timescale 1ns/1ns
`default_nettype none
`include "mpjs_defines.svh"
module mpjs_sequencer (
	input wire logic clk,
	input wire logic nrst,
	input wire logic home_entry_in,
	input wire logic start_entry_in,
	input wire logic branch_input_a,
	input wire logic branch_input_b,
	input wire logic stop_in,
	input wire logic combo_start_stop_in,
	input wire logic combo_enable,
	input wire logic jog_pos_in,
	input wire logic jog_neg_in,
	input wire logic course_program_active,
	input wire logic jog_mode_enable,
	input wire logic direct_start,
	input wire mpjs_pkg::mpjs_set_t direct_set,
	input wire mpjs_pkg::mpjs_set_t home_set,
	input wire mpjs_pkg::mpjs_set_t start_set,
	input wire mpjs_pkg::mpjs_setcfg_s set_cfg,
	input wire mpjs_pkg::mpjs_jogcfg_s jog_cfg,
	input wire logic run_done,
	input wire mpjs_pkg::mpjs_pos_t target_pos,
	input wire mpjs_pkg::mpjs_pos_t setpoint_pos,
	input wire mpjs_pkg::mpjs_pos_t actual_pos,
	input wire mpjs_pkg::mpjs_pos_t tolerance,
	input wire mpjs_pkg::mpjs_pos_t remaining_dist,
	input wire logic homing_done_ok,
	input wire logic homing_start,
	input wire mpjs_pkg::mpjs_pos_t [`MPJS_NTRIG-1:0] trig_pos,
	output mpjs_pkg::mpjs_set_t cfg_set_sel,
	output logic run_start,
	output var mpjs_pkg::mpjs_set_t run_set,
	output logic program_busy,
	output var logic jog_active,
	output var logic jog_dir_neg,
	output var mpjs_pkg::mpjs_spd_t jog_speed,
	output var mpjs_pkg::mpjs_spd_t jog_accel,
	output var mpjs_pkg::mpjs_msg_s msg_out
);
	import mpjs_pkg::*;

	////////////////////////////////////////////////////////////////
	// input synchronisers
	localparam int NSYNC = `MPJS_NSYNC;
	logic [NSYNC-1:0] raw_w;
	logic [NSYNC-1:0] s1_q;
	logic [NSYNC-1:0] s2_q;
	logic [NSYNC-1:0] s3_q;
	assign raw_w = {home_entry_in, start_entry_in, branch_input_a, branch_input_b,
		stop_in, combo_start_stop_in, jog_pos_in, jog_neg_in};
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					s1_q[gi] <= 1'b0;
					s2_q[gi] <= 1'b0;
					s3_q[gi] <= 1'b0;
				end else begin
					s1_q[gi] <= raw_w[gi];
					s2_q[gi] <= s1_q[gi];
					s3_q[gi] <= s2_q[gi];
				end
			end
		end
	endgenerate
	logic home_w, start_w, br_a_w, br_b_w, stop_w, combo_w, jp_w, jn_w;
	assign {home_w, start_w, br_a_w, br_b_w, stop_w, combo_w, jp_w, jn_w} = s2_q;
	logic home_rise_w, start_rise_w, stop_rise_w, combo_rise_w;
	assign home_rise_w = home_w & ~s3_q[`MPJS_SB_HOME];
	assign start_rise_w = start_w & ~s3_q[`MPJS_SB_START];
	assign stop_rise_w = stop_w & ~s3_q[`MPJS_SB_STOP];
	assign combo_rise_w = combo_enable & combo_w & ~s3_q[`MPJS_SB_COMBO];

	////////////////////////////////////////////////////////////////
	// sequencer
	mpjs_state_e state_q, state_d;
	mpjs_set_t set_q, set_d;
	logic stop_pend_q, stop_pend_d;
	logic halt_after_q, halt_after_d;
	logic rec_a_q, rec_b_q;
	logic run_start_d;
	assign cfg_set_sel = set_q;
	assign program_busy = (state_q == MPJS_MOVE);

	logic entry_w;
	mpjs_set_t entry_set_w;
	assign entry_w = direct_start | home_rise_w | start_rise_w | combo_rise_w;
	assign entry_set_w = direct_start ? direct_set :
		home_rise_w ? home_set : start_set;

	logic stop_req_w;
	assign stop_req_w = stop_rise_w | (combo_rise_w & program_busy);

	logic any_stop_w;
	assign any_stop_w = stop_req_w | stop_pend_q;

	// branch choice: a over b, else first following position
	function automatic mpjs_set_t pick_next(input mpjs_setcfg_s c, input logic a, input logic b);
		if (!c.branching)
			return c.next_a;
		else if (a)
			return c.next_a;
		else if (b)
			return c.next_b;
		else
			return c.next_a;
	endfunction
	mpjs_set_t next_set_w;
	assign next_set_w = pick_next(set_cfg, rec_a_q, rec_b_q);

	logic jog_req_w;
	assign jog_req_w = jog_mode_enable & (jp_w ^ jn_w);

	always_comb begin
		state_d = state_q;
		set_d = set_q;
		stop_pend_d = stop_pend_q;
		halt_after_d = halt_after_q;
		run_start_d = 1'b0;
		unique case (state_q)
			MPJS_IDLE: begin
				stop_pend_d = 1'b0;
				halt_after_d = 1'b0;
				if (entry_w) begin
					state_d = MPJS_MOVE;
					set_d = entry_set_w;
					run_start_d = 1'b1;
				end else if (jog_req_w) begin
					state_d = MPJS_JOG;
				end
			end
			MPJS_MOVE: begin
				if (stop_req_w && set_cfg.ignore_stop)
					stop_pend_d = 1'b1;
				if (run_done) begin
					if (!course_program_active || set_cfg.is_final || halt_after_q) begin
						state_d = MPJS_IDLE;
					end else if (any_stop_w && !set_cfg.ignore_stop) begin
						state_d = MPJS_IDLE;
					end else begin
						set_d = next_set_w;
						run_start_d = 1'b1;
						halt_after_d = stop_pend_d;
						stop_pend_d = 1'b0;
					end
				end else if (stop_req_w && !set_cfg.ignore_stop) begin
					state_d = MPJS_IDLE;
				end
				if (halt_after_q && !set_cfg.ignore_stop)
					halt_after_d = 1'b1;
				else if (halt_after_q && set_cfg.ignore_stop && !run_done) begin
					halt_after_d = 1'b0;
					stop_pend_d = 1'b1;
				end
			end
			MPJS_JOG: begin
				if (!jog_req_w)
					state_d = MPJS_IDLE;
			end
			default: state_d = MPJS_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= MPJS_IDLE;
			set_q <= `MPJS_SET_ZERO;
			stop_pend_q <= 1'b0;
			halt_after_q <= 1'b0;
		end else begin
			state_q <= state_d;
			set_q <= set_d;
			stop_pend_q <= stop_pend_d;
			halt_after_q <= halt_after_d;
		end
	end

	// latest branch levels, sampled every cycle
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rec_a_q <= 1'b0;
			rec_b_q <= 1'b0;
		end else begin
			rec_a_q <= br_a_w;
			rec_b_q <= br_b_w;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			run_start <= 1'b0;
			run_set <= `MPJS_SET_ZERO;
		end else begin
			run_start <= run_start_d;
			run_set <= set_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// jog outputs
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			jog_active <= 1'b0;
			jog_dir_neg <= 1'b0;
			jog_speed <= `MPJS_SPD_ZERO;
			jog_accel <= `MPJS_SPD_ZERO;
		end else begin
			jog_active <= (state_d == MPJS_JOG);
			jog_dir_neg <= jn_w;
			jog_speed <= jn_w ? jog_cfg.neg_speed : jog_cfg.pos_speed;
			jog_accel <= jn_w ? jog_cfg.neg_accel : jog_cfg.pos_accel;
		end
	end

	////////////////////////////////////////////////////////////////
	// completion messages
	logic [`MPJS_POS_W-1:0] err_w;
	assign err_w = (actual_pos >= target_pos) ? actual_pos - target_pos : target_pos - actual_pos;
	logic [`MPJS_NTRIG-1:0] trig_w;
	generate
		for (gi = 0; gi < `MPJS_NTRIG; gi++) begin : g_trig
			assign trig_w[gi] = (actual_pos == trig_pos[gi]);
		end
	endgenerate
	logic homed_q;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			homed_q <= 1'b0;
		else if (homing_done_ok)
			homed_q <= 1'b1;
		else if (homing_start)
			homed_q <= 1'b0;
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			msg_out <= '0;
		end else begin
			msg_out.setpoint_at_target <= (setpoint_pos == target_pos);
			msg_out.actual_at_target <= (err_w <= tolerance);
			msg_out.remain_reached <= program_busy && (remaining_dist <= set_cfg.remain_msg);
			msg_out.homing_valid <= homed_q;
			msg_out.trigger_hit <= |trig_w;
		end
	end

	////////////////////////////////////////////////////////////////
	// assertions
	sequence final_arrive_s;
		program_busy && run_done && set_cfg.is_final;
	endsequence
	final_stop_a: assert property (@(posedge clk) disable iff (!nrst)
		final_arrive_s |=> state_q == MPJS_IDLE && !run_start) else $error("final set did not end program");
	stop_halt_a: assert property (@(posedge clk) disable iff (!nrst)
		program_busy && stop_req_w && !set_cfg.ignore_stop |=> !program_busy) else $error("stop not honoured");
	ignore_latch_a: assert property (@(posedge clk) disable iff (!nrst)
		program_busy && !run_done && stop_req_w && set_cfg.ignore_stop |=> stop_pend_q || halt_after_q)
		else $error("ignored stop not latched");
	branch_a_pick_a: assert property (@(posedge clk) disable iff (!nrst)
		program_busy && run_done && course_program_active && set_cfg.branching && !set_cfg.is_final
		&& !halt_after_q && !any_stop_w && rec_a_q |=> run_set == $past(set_cfg.next_a))
		else $error("branch a not taken");
	single_set_a: assert property (@(posedge clk) disable iff (!nrst)
		program_busy && run_done && !course_program_active |=> !program_busy) else $error("chained without program");
	direct_go_a: assert property (@(posedge clk) disable iff (!nrst)
		state_q == MPJS_IDLE && direct_start |=> run_start && run_set == $past(direct_set))
		else $error("direct start ignored");
	jog_gate_a: assert property (@(posedge clk) disable iff (!nrst)
		!jog_mode_enable |=> !jog_active) else $error("jog without enable");
	jog_release_a: assert property (@(posedge clk) disable iff (!nrst)
		state_q == MPJS_JOG && !jog_req_w |=> !jog_active) else $error("jog kept moving");
	idle_hold_a: assert property (@(posedge clk) disable iff (!nrst)
		state_q == MPJS_IDLE && !entry_w |=> !run_start) else $error("started without entry");
	sequence chain_arrive_s;
		program_busy && run_done && course_program_active && !set_cfg.is_final && !halt_after_q;
	endsequence
	branch_b_pick_a: assert property (@(posedge clk) disable iff (!nrst)
		chain_arrive_s ##0 (set_cfg.branching && !any_stop_w && !rec_a_q && rec_b_q)
		|=> run_start && run_set == $past(set_cfg.next_b)) else $error("branch b not taken");
	chain_next_a: assert property (@(posedge clk) disable iff (!nrst)
		chain_arrive_s ##0 (!set_cfg.branching && !any_stop_w)
		|=> run_start && run_set == $past(set_cfg.next_a)) else $error("chain step missed");
	ignore_carry_a: assert property (@(posedge clk) disable iff (!nrst)
		chain_arrive_s ##0 (set_cfg.ignore_stop && any_stop_w)
		|=> run_start && halt_after_q) else $error("ignored stop not carried");
	halt_follow_a: assert property (@(posedge clk) disable iff (!nrst)
		program_busy && run_done && halt_after_q |=> !program_busy && !run_start)
		else $error("no halt after ignored stop");
	home_entry_a: assert property (@(posedge clk) disable iff (!nrst)
		state_q == MPJS_IDLE && home_rise_w && !direct_start
		|=> run_start && run_set == $past(home_set)) else $error("home entry missed");
	start_entry_a: assert property (@(posedge clk) disable iff (!nrst)
		state_q == MPJS_IDLE && start_rise_w && !direct_start && !home_rise_w
		|=> run_start && run_set == $past(start_set)) else $error("start entry missed");
	combo_start_a: assert property (@(posedge clk) disable iff (!nrst)
		state_q == MPJS_IDLE && combo_rise_w && !direct_start && !home_rise_w && !start_rise_w
		|=> run_start && run_set == $past(start_set)) else $error("combined start missed");
	combo_stop_a: assert property (@(posedge clk) disable iff (!nrst)
		program_busy && combo_rise_w && !set_cfg.ignore_stop |=> !program_busy)
		else $error("combined stop missed");
	busy_refuse_a: assert property (@(posedge clk) disable iff (!nrst)
		program_busy && !run_done |=> !run_start) else $error("start while running");
	stop_idle_a: assert property (@(posedge clk) disable iff (!nrst)
		state_q == MPJS_IDLE && stop_rise_w && !entry_w && !jog_req_w |=> state_q == MPJS_IDLE)
		else $error("idle stop not discarded");
	jog_enter_a: assert property (@(posedge clk) disable iff (!nrst)
		state_q == MPJS_IDLE && !entry_w && jog_req_w |=> jog_active) else $error("jog not entered");
	jog_neg_cfg_a: assert property (@(posedge clk) disable iff (!nrst)
		jog_active && jog_dir_neg
		|-> jog_speed == $past(jog_cfg.neg_speed) && jog_accel == $past(jog_cfg.neg_accel))
		else $error("negative jog profile wrong");
	jog_pos_cfg_a: assert property (@(posedge clk) disable iff (!nrst)
		jog_active && !jog_dir_neg
		|-> jog_speed == $past(jog_cfg.pos_speed) && jog_accel == $past(jog_cfg.pos_accel))
		else $error("positive jog profile wrong");
	home_msg_a: assert property (@(posedge clk) disable iff (!nrst)
		homing_done_ok |=> ##1 msg_out.homing_valid) else $error("homing valid missing");
	unhomed_msg_a: assert property (@(posedge clk) disable iff (!nrst)
		!homed_q |=> !msg_out.homing_valid) else $error("homing valid without homing");
	setpoint_msg_a: assert property (@(posedge clk) disable iff (!nrst)
		setpoint_pos == target_pos |=> msg_out.setpoint_at_target) else $error("setpoint message missing");
	remain_idle_a: assert property (@(posedge clk) disable iff (!nrst)
		!program_busy |=> !msg_out.remain_reached) else $error("remain message while idle");
endmodule
`default_nettype wire

// [mpjs_motion_model.sv]
`timescale 1ns/1ns
`default_nettype none
module mpjs_motion_model (
	input wire logic clk,
	input wire logic nrst,
	input wire logic run_start,
	input wire mpjs_pkg::mpjs_set_t cfg_set_sel,
	output logic run_done,
	output mpjs_pkg::mpjs_setcfg_s set_cfg
);
	import mpjs_pkg::*;
	logic [3:0] cnt_q;
	////////////////////////////////////////////////////////////////
	// each move takes eight cycles, done pulses once at the end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) cnt_q <= 4'h0;
		else if (run_start) cnt_q <= 4'h8;
		else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
	end
	assign run_done = (cnt_q == 4'h1);
	////////////////////////////////////////////////////////////////
	// 1->2 end, 5 branches to 6 or 9, 6 runs through stop, 6->7->8 end
	always_comb begin
		set_cfg = '{1'b1, 1'b0, 1'b0, 6'h00, 6'h00, 32'h0000_0010};
		case (cfg_set_sel)
			6'h01, 6'h07: begin
				set_cfg.is_final = 1'b0;
				set_cfg.next_a = cfg_set_sel + 6'h01;
			end
			6'h05: begin
				set_cfg.is_final = 1'b0;
				set_cfg.branching = 1'b1;
				set_cfg.next_a = 6'h06;
				set_cfg.next_b = 6'h09;
			end
			6'h06: begin
				set_cfg.is_final = 1'b0;
				set_cfg.ignore_stop = 1'b1;
				set_cfg.next_a = 6'h07;
			end
			default: ;
		endcase
	end
endmodule
`default_nettype wire

// [tb_mpjs_sequencer.sv]
`timescale 1ns/1ns
`default_nettype none
`include "mpjs_defines.svh"
module tb_mpjs_sequencer;
	import mpjs_pkg::*;
	logic clk, nrst, home_entry_in, start_entry_in, branch_input_a, branch_input_b, stop_in;
	logic combo_start_stop_in, combo_enable, jog_pos_in, jog_neg_in, course_program_active;
	logic jog_mode_enable, direct_start, run_done, homing_done_ok, homing_start;
	logic run_start, program_busy, jog_active, jog_dir_neg;
	mpjs_set_t direct_set, home_set, start_set, cfg_set_sel, run_set;
	mpjs_setcfg_s set_cfg;
	mpjs_jogcfg_s jog_cfg;
	mpjs_pos_t target_pos, setpoint_pos, actual_pos, tolerance, remaining_dist;
	mpjs_pos_t [`MPJS_NTRIG-1:0] trig_pos;
	mpjs_spd_t jog_speed, jog_accel;
	mpjs_msg_s msg_out;
	int bad_count, num_checks;
	mpjs_sequencer mpjs_sequencer_inst (
		.clk(clk), .nrst(nrst), .home_entry_in(home_entry_in), .start_entry_in(start_entry_in),
		.branch_input_a(branch_input_a), .branch_input_b(branch_input_b), .stop_in(stop_in),
		.combo_start_stop_in(combo_start_stop_in), .combo_enable(combo_enable), .jog_pos_in(jog_pos_in),
		.jog_neg_in(jog_neg_in), .course_program_active(course_program_active),
		.jog_mode_enable(jog_mode_enable), .direct_start(direct_start), .direct_set(direct_set),
		.home_set(home_set), .start_set(start_set), .set_cfg(set_cfg), .jog_cfg(jog_cfg),
		.run_done(run_done), .target_pos(target_pos), .setpoint_pos(setpoint_pos),
		.actual_pos(actual_pos), .tolerance(tolerance), .remaining_dist(remaining_dist),
		.homing_done_ok(homing_done_ok), .homing_start(homing_start), .trig_pos(trig_pos),
		.cfg_set_sel(cfg_set_sel), .run_start(run_start), .run_set(run_set), .program_busy(program_busy),
		.jog_active(jog_active), .jog_dir_neg(jog_dir_neg), .jog_speed(jog_speed), .jog_accel(jog_accel),
		.msg_out(msg_out)
	);
	mpjs_motion_model mpjs_motion_model_inst (
		.clk(clk), .nrst(nrst), .run_start(run_start), .cfg_set_sel(cfg_set_sel),
		.run_done(run_done), .set_cfg(set_cfg)
	);
	////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
	endtask
	task automatic wait_start(input mpjs_set_t s);
		for (int i = 0; i < 40 && run_start !== 1'b1; i++) tick(1);
		chk("run_start", run_start, 1);
		chk("run_set", run_set, s);
		chk("cfg_set_sel", cfg_set_sel, s);
		tick(1);
	endtask
	task automatic wait_idle();
		for (int i = 0; i < 40 && program_busy !== 1'b0; i++) tick(1);
		chk("program_busy", program_busy, 0);
	endtask
	task automatic final_report();
		if (bad_count == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		#200000;
		bad_count++;
		final_report();
	end
	initial begin
		{nrst, home_entry_in, start_entry_in, branch_input_a, branch_input_b, stop_in} = '0;
		{combo_start_stop_in, combo_enable, jog_pos_in, jog_neg_in, jog_mode_enable} = '0;
		{direct_start, homing_done_ok, homing_start, trig_pos} = '0;
		course_program_active = 1'b1;
		{direct_set, home_set, start_set} = {6'h01, 6'h01, 6'h05};
		{target_pos, setpoint_pos, actual_pos} = {32'h0000_0064, 32'h0000_0064, 32'h0000_0067};
		{tolerance, remaining_dist} = {32'h0000_0004, 32'h0000_0010};
		trig_pos[2] = 32'h0000_0067;
		jog_cfg = {16'h0011, 16'h0022, 16'h0033, 16'h0044};
		tick(16);
		nrst = 1'b1;
		tick(3);
		chk("reset busy", program_busy, 0);
		chk("reset start", run_start, 0);
		pulse(direct_start);
		wait_start(6'h01);
		chk("remain", msg_out.remain_reached, 1);
		remaining_dist = 32'h0000_0011;
		tick(2);
		chk("remain far", msg_out.remain_reached, 0);
		remaining_dist = 32'h0000_0010;
		wait_start(6'h02);
		wait_idle();
		tick(1);
		chk("remain idle", msg_out.remain_reached, 0);
		course_program_active = 1'b0;
		pulse(home_entry_in);
		wait_start(6'h01);
		wait_idle();
		chk("single set", run_set, 6'h01);
		course_program_active = 1'b1;
		branch_input_b = 1'b1;
		pulse(start_entry_in);
		wait_start(6'h05);
		wait_start(6'h09);
		wait_idle();
		direct_set = 6'h05;
		pulse(direct_start);
		wait_start(6'h05);
		branch_input_a = 1'b1;
		wait_start(6'h06);
		wait_start(6'h07);
		pulse(stop_in);
		tick(6);
		chk("stop", program_busy, 0);
		chk("stop set", run_set, 6'h07);
		{branch_input_a, branch_input_b} = 2'b00;
		direct_set = 6'h06;
		pulse(direct_start);
		wait_start(6'h06);
		pulse(stop_in);
		wait_start(6'h07);
		wait_idle();
		tick(20);
		chk("stay idle", program_busy, 0);
		chk("halt set", run_set, 6'h07);
		combo_enable = 1'b1;
		pulse(combo_start_stop_in);
		wait_start(6'h05);
		pulse(combo_start_stop_in);
		tick(5);
		chk("combo stop", program_busy, 0);
		jog_pos_in = 1'b1;
		tick(6);
		chk("jog off", jog_active, 0);
		jog_mode_enable = 1'b1;
		tick(6);
		chk("jog pos", jog_active, 1);
		chk("jog dir", jog_dir_neg, 0);
		chk("jog speed", jog_speed, 16'h0011);
		chk("jog accel", jog_accel, 16'h0022);
		jog_pos_in = 1'b0;
		tick(6);
		chk("jog release", jog_active, 0);
		jog_neg_in = 1'b1;
		tick(6);
		chk("jog neg", jog_dir_neg, 1);
		chk("jog speed n", jog_speed, 16'h0033);
		chk("jog accel n", jog_accel, 16'h0044);
		chk("jog neg on", jog_active, 1);
		jog_pos_in = 1'b1;
		tick(6);
		chk("jog both", jog_active, 0);
		{jog_pos_in, jog_neg_in} = 2'b00;
		chk("not homed", msg_out.homing_valid, 0);
		pulse(homing_done_ok);
		tick(2);
		chk("homed", msg_out.homing_valid, 1);
		chk("setpoint", msg_out.setpoint_at_target, 1);
		chk("window in", msg_out.actual_at_target, 1);
		chk("trigger", msg_out.trigger_hit, 1);
		{setpoint_pos, actual_pos} = {32'h0000_0063, 32'h0000_0069};
		tick(3);
		chk("setpoint off", msg_out.setpoint_at_target, 0);
		chk("window out", msg_out.actual_at_target, 0);
		chk("trigger off", msg_out.trigger_hit, 0);
		pulse(homing_start);
		tick(2);
		chk("unhomed", msg_out.homing_valid, 0);
		final_report();
	end
endmodule
`default_nettype wire
